// file: design/limiter_config_fault_status.sv
// Limiter configuration registers and protection status register.
`timescale 1ns/10ps
module limiter_config_fault_status
    import lim_status_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic [2:0] i_battery_inflection_point,
    input wire logic i_battery_at_or_below,
    input wire fault_cond_t i_fault_cond,
    output logic [7:0] o_limiter_rate_threshold_cfg,
    output logic [7:0] o_detector_hysteresis_cfg,
    output logic [7:0] o_protection_fault_flags,
    output limiter_setting_t o_setting
);

    ////////////////////////////////////////////////////////////////////////
    logic rst_s1_ff;
    logic rst_n_ff;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] lim_cfg_ff;
    logic [7:0] det_cfg_ff;
    logic [7:0] flags_ff;
    logic [7:0] rdata_ff;

    wire sel_lim = (i_reg_addr == LIM_CFG_ADDR);
    wire sel_det = (i_reg_addr == DET_CFG_ADDR);
    wire sel_flags = (i_reg_addr == FLAGS_ADDR);
    wire wr_lim = i_reg_wr && sel_lim;
    wire wr_det = i_reg_wr && sel_det;

    always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lim_cfg_ff <= LIM_CFG_RESET;
            det_cfg_ff <= DET_CFG_RESET;
        end else if (i_ce) begin
            if (wr_lim) begin
                lim_cfg_ff <= i_reg_wdata;
            end
            if (wr_det) begin
                det_cfg_ff <= i_reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition inputs come from analog monitors, so they are synchronised.
    logic [6:0] cond_sync;
    wire [6:0] cond_raw = {i_fault_cond.boost_fault,
                           i_fault_cond.gain_reduced,
                           i_fault_cond.clipping,
                           i_fault_cond.undervoltage,
                           i_fault_cond.amp_overcurrent,
                           i_fault_cond.overtemp,
                           i_battery_at_or_below};

    flag_sync #(
        .WIDTH(7)
    ) u_flag_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(rst_n_ff),
        .i_ce(i_ce),
        .i_async(cond_raw),
        .o_sync(cond_sync)
    );

    logic [7:0] nxt_flags;
    always_comb begin
        nxt_flags = 8'h00;
        nxt_flags[BOOST_BIT] = cond_sync[6];
        nxt_flags[GAIN_BIT] = cond_sync[5];
        nxt_flags[CLIP_BIT] = cond_sync[4];
        nxt_flags[UV_BIT] = cond_sync[3];
        nxt_flags[OC_BIT] = cond_sync[2];
        nxt_flags[OT_BIT] = cond_sync[1];
        nxt_flags[BATT_BIT] = cond_sync[0];
    end

    // Flags are live levels, not sticky; a read never alters them.
    always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            flags_ff <= FLAGS_RESET;
        end else if (i_ce) begin
            flags_ff <= nxt_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire [7:0] rd_mux = sel_lim ? lim_cfg_ff :
                        sel_det ? det_cfg_ff :
                        sel_flags ? flags_ff : 8'h00;

    always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 8'h00;
        end else if (i_ce && i_reg_rd) begin
            rdata_ff <= rd_mux;
        end
    end

    assign o_reg_rdata = rdata_ff;
    assign o_limiter_rate_threshold_cfg = lim_cfg_ff;
    assign o_detector_hysteresis_cfg = det_cfg_ff;
    assign o_protection_fault_flags = flags_ff;

    ////////////////////////////////////////////////////////////////////////
    wire [1:0] release_rate_sel = lim_cfg_ff[RELEASE_LSB +: 2];
    wire [1:0] attack_rate_sel = lim_cfg_ff[ATTACK_LSB +: 2];
    wire [3:0] attack_threshold_sel = lim_cfg_ff[THRESH_LSB +: 4];
    wire detector_averaging_sel = det_cfg_ff[AVG_BIT];
    wire [2:0] hyst_sel = det_cfg_ff[HYST_LSB +: 3];

    logic [11:0] release_ms;
    logic [6:0] attack_us;
    always_comb begin
        unique case (release_rate_sel)
            2'h0: release_ms = RELEASE_MS_0;
            2'h1: release_ms = RELEASE_MS_1;
            2'h2: release_ms = RELEASE_MS_2;
            2'h3: release_ms = RELEASE_MS_3;
        endcase
        unique case (attack_rate_sel)
            2'h0: attack_us = ATTACK_US_0;
            2'h1: attack_us = ATTACK_US_1;
            2'h2: attack_us = ATTACK_US_2;
            2'h3: attack_us = ATTACK_US_3;
        endcase
    end

    wire [6:0] thresh_drop = 7'({3'h0, attack_threshold_sel} * THRESH_STEP_DV);
    wire [6:0] thresh_dv = THRESH_TOP_DV - thresh_drop;
    wire signed [7:0] hyst_dbv = HYST_BASE_DBV +
        8'(signed'({5'h00, hyst_sel}) * HYST_STEP_DB);
    wire [5:0] infl_dv = INFL_TOP_DV -
        {3'h0, i_battery_inflection_point};

    always_comb begin
        o_setting.release_ms_per_db = release_ms;
        o_setting.attack_us_per_db = attack_us;
        o_setting.attack_threshold_dv = thresh_dv;
        o_setting.detector_averaging_sel = detector_averaging_sel;
        o_setting.hyst_enable = (hyst_sel != 3'h0);
        o_setting.hyst_dbv = (hyst_sel != 3'h0) ? hyst_dbv : 8'sd0;
        o_setting.battery_inflection_dv = infl_dv;
    end

endmodule

// file: design/lim_status_pkg.sv
// Package with offsets, field layout, reset values and decode constants.
package lim_status_pkg;

    localparam int ADDR_W = 8;
    localparam logic [7:0] LIM_CFG_ADDR = 8'h0e;
    localparam logic [7:0] DET_CFG_ADDR = 8'h0f;
    localparam logic [7:0] FLAGS_ADDR = 8'h10;

    localparam logic [7:0] LIM_CFG_RESET = 8'h73;
    localparam logic [7:0] DET_CFG_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    localparam int RELEASE_LSB = 6;
    localparam int ATTACK_LSB = 4;
    localparam int THRESH_LSB = 0;
    localparam int AVG_BIT = 3;
    localparam int HYST_LSB = 0;

    localparam int BOOST_BIT = 7;
    localparam int GAIN_BIT = 5;
    localparam int CLIP_BIT = 4;
    localparam int UV_BIT = 3;
    localparam int OC_BIT = 2;
    localparam int OT_BIT = 1;
    localparam int BATT_BIT = 0;

    // Release rate in ms/dB for codes 0 to 3.
    localparam logic [11:0] RELEASE_MS_0 = 12'hc80;
    localparam logic [11:0] RELEASE_MS_1 = 12'h640;
    localparam logic [11:0] RELEASE_MS_2 = 12'h4b0;
    localparam logic [11:0] RELEASE_MS_3 = 12'h320;
    // Attack rate in us/dB for codes 0 to 3.
    localparam logic [6:0] ATTACK_US_0 = 7'h78;
    localparam logic [6:0] ATTACK_US_1 = 7'h3c;
    localparam logic [6:0] ATTACK_US_2 = 7'h1e;
    localparam logic [6:0] ATTACK_US_3 = 7'h14;
    // Threshold in units of 0.1 V: 6.6 V at code 0, 0.2 V less per code.
    localparam logic [6:0] THRESH_TOP_DV = 7'h42;
    localparam logic [6:0] THRESH_STEP_DV = 7'h02;
    // Inflection point in units of 0.1 V: 3.9 V at code 0, 0.1 V per code.
    localparam logic [5:0] INFL_TOP_DV = 6'h27;
    // Hysteresis in dBV: -36 at code 1, 3 dB per code; code 0 is none.
    localparam logic signed [7:0] HYST_BASE_DBV = -8'sd39;
    localparam logic signed [7:0] HYST_STEP_DB = 8'sd3;

    typedef struct packed {
        logic boost_fault;
        logic gain_reduced;
        logic clipping;
        logic undervoltage;
        logic amp_overcurrent;
        logic overtemp;
    } fault_cond_t;

    typedef struct packed {
        logic [11:0] release_ms_per_db;
        logic [6:0] attack_us_per_db;
        logic [6:0] attack_threshold_dv;
        logic detector_averaging_sel;
        logic hyst_enable;
        logic signed [7:0] hyst_dbv;
        logic [5:0] battery_inflection_dv;
    } limiter_setting_t;

endpackage

// file: design/flag_sync.sv
// Three-stage synchroniser bank with agreement check for condition pins.
`timescale 1ns/10ps
module flag_sync
    import lim_status_pkg::*;
#(
    parameter int WIDTH = 7
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            wire agree = (s2_ff == s3_ff);
            always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    out_ff <= 1'b0;
                end else if (i_ce) begin
                    s1_ff <= i_async[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (agree) begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign o_sync[g] = out_ff;
        end
    endgenerate

endmodule

// file: tb/lim_status_monitor.sv
// Port checker for the limiter configuration and status block.
`timescale 1ns/10ps
module lim_status_monitor
    import lim_status_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_battery_at_or_below,
    input wire fault_cond_t i_fault_cond,
    input wire logic [7:0] o_limiter_rate_threshold_cfg,
    input wire logic [7:0] o_detector_hysteresis_cfg,
    input wire logic [7:0] o_protection_fault_flags
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    wire logic unmapped = i_reg_addr < 8'h0e || i_reg_addr > 8'h10;
    sequence wr_to(a);
        i_ce && i_reg_wr && i_reg_addr == a;
    endsequence
    sequence rd_of(a);
        i_ce && i_reg_rd && i_reg_addr == a;
    endsequence
    // A level held ten enabled cycles has cleared reset and the sync stages.
    sequence held(c);
        (i_ce && c)[*8] ##1 (i_ce && c)[*2];
    endsequence
    cfg_write_a: assert property (wr_to(8'h0e) |=>
        o_limiter_rate_threshold_cfg == $past(i_reg_wdata))
        else $error("limiter config write not stored");
    det_write_a: assert property (wr_to(8'h0f) |=>
        o_detector_hysteresis_cfg == $past(i_reg_wdata))
        else $error("detector config write not stored");
    lim_read_a: assert property (rd_of(8'h0e) |=>
        o_reg_rdata == $past(o_limiter_rate_threshold_cfg))
        else $error("limiter config read wrong");
    flag_read_a: assert property (rd_of(8'h10) |=>
        o_reg_rdata == $past(o_protection_fault_flags))
        else $error("status read wrong");
    unmapped_read_a: assert property (i_ce && i_reg_rd && unmapped
        |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    reserved_zero_a: assert property (
        o_protection_fault_flags[6] == 1'b0) else $error("bit 6 set");
    boost_set_a: assert property (held(i_fault_cond.boost_fault)
        |-> o_protection_fault_flags[7]) else $error("boost flag missing");
    battery_clear_a: assert property (held(!i_battery_at_or_below)
        |-> !o_protection_fault_flags[0]) else $error("battery flag stuck");
    reset_value_a: assert property ($rose(i_arst_n) |->
        {o_limiter_rate_threshold_cfg, o_detector_hysteresis_cfg,
        o_protection_fault_flags} == 24'h730000)
        else $error("reset values wrong");
endmodule

bind limiter_config_fault_status lim_status_monitor u_lim_status_monitor (.*);

// file: tb/testbench.sv
// Self-checking bench for the limiter configuration and status block.
`timescale 1ns/10ps
module testbench;
    import lim_status_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_rd = 1'b0;
    logic [2:0] i_battery_inflection_point = 3'h0;
    logic i_battery_at_or_below = 1'b0;
    fault_cond_t i_fault_cond = '0;
    logic [7:0] o_reg_rdata, o_limiter_rate_threshold_cfg;
    logic [7:0] o_detector_hysteresis_cfg, o_protection_fault_flags;
    limiter_setting_t o_setting;
    int err_total = 0;
    int checks = 0;
    int rel_ms[4] = '{3200, 1600, 1200, 800};
    int atk_us[4] = '{120, 60, 30, 20};
    limiter_config_fault_status u_limiter_config_fault_status (.*);
    initial forever #50 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        @(negedge i_ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_reg_rdata, exp);
    endtask
    task automatic t_reset;
        chk(o_limiter_rate_threshold_cfg, 8'h73);
        chk(o_detector_hysteresis_cfg, 8'h00);
        chk(o_protection_fault_flags, 8'h00);
    endtask
    task automatic t_limiter;
        logic [7:0] d;
        for (int i = 0; i < 16; i++) begin
            d = {i[1:0], i[3:2], i[3:0]};
            wr(8'h0e, d);
            rd(8'h0e, d);
            chk(o_setting.release_ms_per_db, 16'(rel_ms[i % 4]));
            chk(o_setting.attack_us_per_db, 16'(atk_us[i / 4]));
            chk(o_setting.attack_threshold_dv, 16'(66 - 2 * i));
        end
    endtask
    task automatic t_detector;
        logic [7:0] d;
        logic [7:0] h;
        for (int i = 0; i < 16; i++) begin
            d = {4'(15 - i), i[3:0]};
            h = (i % 8 == 0) ? 8'h00 : 8'(3 * (i % 8) - 39);
            wr(8'h0f, d);
            rd(8'h0f, d);
            chk(o_setting.detector_averaging_sel, i[3]);
            chk(o_setting.hyst_enable, i % 8 != 0);
            chk({8'h00, o_setting.hyst_dbv}, {8'h00, h});
        end
    endtask
    task automatic t_flags;
        logic [7:0] e;
        for (int b = 0; b < 10; b++) begin
            e = (b < 8) ? 8'(1 << b) : ((b == 8) ? 8'hff : 8'h00);
            @(posedge i_ref_clk);
            i_fault_cond <= {e[7], e[5:1]};
            i_battery_at_or_below <= e[0];
            i_battery_inflection_point <= 3'(b);
            repeat (6) @(posedge i_ref_clk);
            @(negedge i_ref_clk);
            chk(o_setting.battery_inflection_dv, 16'(39 - b % 8));
            chk(o_protection_fault_flags, e & 8'hbf);
            rd(8'h10, e & 8'hbf);
            wr(8'h10, ~e);
            rd(8'h10, e & 8'hbf);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        err_total++;
        stop_test;
    end
    initial begin
        // A real falling edge so the asynchronous reset branches fire.
        i_arst_n <= 1'b0;
        repeat (5) @(posedge i_ref_clk);
        t_reset;
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        rd(8'h0e, 8'h73);
        t_limiter;
        t_detector;
        t_flags;
        rd(8'h11, 8'h00);
        wr(8'h11, 8'h55);
        @(posedge i_ref_clk);
        i_ce <= 1'b0;
        wr(8'h0e, 8'h12);
        chk(o_limiter_rate_threshold_cfg, 8'hff);
        @(posedge i_ref_clk);
        i_ce <= 1'b1;
        @(posedge i_ref_clk);
        i_arst_n <= 1'b0;
        @(negedge i_ref_clk);
        t_reset;
        stop_test;
    end
endmodule
